/* include/amp_cmd_pkg.sv */
package amp_cmd_pkg;

    // --------------------------------------------------------------
    // register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [5:0] OFF_CMD = 6'h00;
    localparam logic [5:0] OFF_PAR1 = 6'h04;
    localparam logic [5:0] OFF_PAR5 = 6'h14;
    localparam logic [5:0] OFF_ACK = 6'h18;
    localparam logic [5:0] OFF_ANS1 = 6'h1C;
    localparam logic [5:0] OFF_ANS5 = 6'h2C;
    localparam logic [5:0] OFF_STATUS = 6'h30;
    localparam logic [5:0] OFF_MASK = 6'h34;
    localparam logic [5:0] OFF_LIMIT = 6'h38;

    // --------------------------------------------------------------
    // command codes written to OFF_CMD
    // --------------------------------------------------------------
    localparam logic [2:0] OP_OUTPUT_ASSIGN = 3'h1;
    localparam logic [2:0] OP_OUTPUT_ASSIGN_QRY = 3'h2;
    localparam logic [2:0] OP_PEAK_STORE_SETUP = 3'h3;
    localparam logic [2:0] OP_PEAK_STORE_QRY = 3'h4;
    localparam logic [2:0] OP_CLEAR_PEAK = 3'h5;
    localparam logic [2:0] OP_LIMIT_SWITCH_SETUP = 3'h6;
    localparam logic [2:0] OP_LIMIT_SWITCH_QRY = 3'h7;

    // --------------------------------------------------------------
    // replies, codes, limits
    // --------------------------------------------------------------
    localparam logic [7:0] ACK_DONE = 8'h30;
    localparam logic [7:0] ACK_ERROR = 8'h3F;
    localparam int REV_NO_ASSIGN = 105;
    localparam logic [2:0] SRC_UNLINKED = 3'h0;
    localparam logic [2:0] SRC_GROSS = 3'h1;
    localparam logic [2:0] SRC_NET = 3'h2;
    localparam logic [2:0] SRC_STORE1 = 3'h3;
    localparam logic [2:0] SRC_STORE2 = 3'h4;
    localparam logic [2:0] SRC_ABS = 3'h5;
    localparam int ADU_FULL_SCALE = 7680000;
    localparam int ENV_MAX_MS = 60000;
    localparam int NUM_SWITCHES = 4;
    localparam int NUM_ANS = 5;

    // --------------------------------------------------------------
    // status bits and timing
    // --------------------------------------------------------------
    localparam int STAT_DONE = 0;
    localparam int STAT_ERROR = 1;
    localparam int STAT_LIMIT = 2;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic on;
        logic signed [3:0] sig;
        logic [15:0] envMs;
    } store_cfg_s;

    typedef struct packed {
        logic on;
        logic [2:0] src;
        logic signed [31:0] closePt;
        logic signed [31:0] openPt;
    } limit_cfg_s;

endpackage

/* core/minmax_store.sv */
`timescale 1ns/100ps
module minmax_store #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rstN,
    input wire amp_cmd_pkg::store_cfg_s cfg,
    input wire logic clearPeak,
    input wire logic msTick,
    input wire logic signed [W-1:0] gross_signal,
    input wire logic signed [W-1:0] net_signal,
    output logic signed [W-1:0] value
);
    logic signed [W-1:0] maxV;
    logic signed [W-1:0] minV;
    logic signed [W-1:0] next_maxV;
    logic signed [W-1:0] next_minV;
    logic signed [W-1:0] src;
    logic [15:0] envCnt;
    logic [15:0] next_envCnt;
    logic restart;

    always_comb
    begin
        src = (cfg.sig == 4'sh2 || cfg.sig == -4'sh2 || cfg.sig == 4'sh4) ? net_signal : gross_signal;
        restart = clearPeak || !cfg.on;
        next_envCnt = envCnt;
        if (cfg.envMs == 16'h0)
        begin
            next_envCnt = 16'h0;
        end
        else if (msTick)
        begin
            if (envCnt + 16'h1 >= cfg.envMs)
            begin
                restart = 1'b1;
                next_envCnt = 16'h0;
            end
            else
            begin
                next_envCnt = envCnt + 16'h1;
            end
        end
        if (restart)
        begin
            next_maxV = src;
            next_minV = src;
        end
        else
        begin
            next_maxV = (src > maxV) ? src : maxV;
            next_minV = (src < minV) ? src : minV;
        end
        if (cfg.sig < 4'sh0)
            value = minV;
        else if (cfg.sig >= 4'sh3)
            value = maxV - minV;
        else
            value = maxV;
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            maxV <= '0;
            minV <= '0;
            envCnt <= 16'h0;
        end
        else
        begin
            maxV <= next_maxV;
            minV <= next_minV;
            envCnt <= next_envCnt;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_clear_follows;
        @(posedge clk) disable iff (!rstN)
        (clearPeak && cfg.sig < 4'sh3) ##1 (cfg == $past(cfg)) |-> value == $past(src);
    endproperty
    a_clear_follows: assert property (p_clear_follows) else $error("store not equal to input after clear");

    property p_max_holds;
        @(posedge clk) disable iff (!rstN)
        (cfg.on && cfg.sig > 4'sh0 && cfg.sig < 4'sh3 && !restart) ##1 $stable(cfg) |-> value >= $past(value);
    endproperty
    a_max_holds: assert property (p_max_holds) else $error("maximum store fell");

    c_envelope: cover property (@(posedge clk) disable iff (!rstN) msTick && cfg.envMs != 16'h0 && restart);
endmodule

/* core/amp_cmd_core.sv */
`timescale 1ns/100ps
// What this block does
// - output assign: output 1 or 2, signal 0 none,1 gross,2 net,3/4 stores
// - every setting command answers 0 when done, question mark on error
// - output assign query returns signal code routed to that output
// - from hardware revision 1.05 output assign and its query are refused
// - peak setup picks store 1 or 2; on/off always applies to both stores
// - store signal code: -1/-2 negative, +1/+2 positive, +3/+4 peak-to-peak
// - envelope parameter 0 is off, else time constant in milliseconds
// - peak query returns store code, on/off, signed signal code, envelope
// - clear-peak clears both stores; a min or max store then equals its present input, a peak-to-peak store reads 0
// - limit setup: switch 1..4, on/off, source 1..5 gross/net/store1/store2/abs
// - switching points are ADU, 7680000 is full scale
// - each switch holds a closing point and an opening point
// - limit query with switch 0 returns level of source code 1..5
// - limit query of switch 1..4 returns number, on, source, close, open
// - gross signal is the measured value without zero or tare
// - net signal is gross minus tare
module amp_cmd_core #(
    parameter int W = 32,
    parameter int HW_REV = 100,
    parameter int MS_CYCLES = amp_cmd_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic signed [W-1:0] measIn,
    input wire logic signed [W-1:0] tareValue,
    input wire logic signed [W-1:0] absolute_signal,
    output logic signed [W-1:0] analog_out_first,
    output logic signed [W-1:0] analog_out_second,
    output logic [3:0] limitClosed,
    output logic irq
);
    localparam bit ASSIGN_OK = HW_REV < amp_cmd_pkg::REV_NO_ASSIGN;

    logic [1:0] rstSync;
    logic rstN;
    logic signed [W-1:0] gross_signal;
    logic signed [W-1:0] net_signal;
    logic signed [W-1:0] minmax_store_first;
    logic signed [W-1:0] minmax_store_second;
    logic signed [W-1:0] storeVal [2];

    logic [31:0] msCnt;
    logic [31:0] next_msCnt;
    logic msTick;
    logic next_msTick;

    logic [31:0] next_readdata;
    logic next_waitrequest;
    logic wrAcc;
    logic cmdGo;
    logic [2:0] opc;

    logic signed [31:0] par [5];
    logic signed [31:0] next_par [5];
    logic signed [31:0] ans [5];
    logic signed [31:0] next_ans [5];
    logic [7:0] ack;
    logic [7:0] next_ack;
    logic [2:0] nAns;
    logic [2:0] next_nAns;
    logic [2:0] assignCode [2];
    logic [2:0] next_assignCode [2];
    amp_cmd_pkg::store_cfg_s storeCfg [2];
    amp_cmd_pkg::store_cfg_s next_storeCfg [2];
    amp_cmd_pkg::limit_cfg_s limCfg [4];
    amp_cmd_pkg::limit_cfg_s next_limCfg [4];
    logic clearPeak;
    logic next_clearPeak;
    logic ok;
    logic err;

    logic [3:0] next_limitClosed;
    logic [2:0] status;
    logic [2:0] next_status;
    logic [2:0] mask;
    logic [2:0] next_mask;
    logic next_irq;
    logic signed [W-1:0] next_aOut [2];

    // --------------------------------------------------------------
    // reset release and signals
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    assign gross_signal = measIn;
    assign net_signal = measIn - tareValue;

    function automatic logic signed [W-1:0] pick(input logic [2:0] code);
        if (code == amp_cmd_pkg::SRC_GROSS)
            pick = gross_signal;
        else if (code == amp_cmd_pkg::SRC_NET)
            pick = net_signal;
        else if (code == amp_cmd_pkg::SRC_STORE1)
            pick = minmax_store_first;
        else if (code == amp_cmd_pkg::SRC_STORE2)
            pick = minmax_store_second;
        else if (code == amp_cmd_pkg::SRC_ABS)
            pick = absolute_signal;
        else
            pick = '0;
    endfunction

    for (genvar s = 0; s < 2; s++)
    begin : g_store
        minmax_store #(.W(W)) u_store (
            .clk(clk),
            .rstN(rstN),
            .cfg(storeCfg[s]),
            .clearPeak(clearPeak),
            .msTick(msTick),
            .gross_signal(gross_signal),
            .net_signal(net_signal),
            .value(storeVal[s])
        );
    end
    assign minmax_store_first = storeVal[0];
    assign minmax_store_second = storeVal[1];

    // --------------------------------------------------------------
    // millisecond tick
    // --------------------------------------------------------------
    always_comb
    begin
        next_msTick = msCnt == 32'(MS_CYCLES - 1);
        next_msCnt = next_msTick ? 32'h0 : msCnt + 32'h1;
    end

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    function automatic logic [31:0] rdMux(input logic [5:0] a);
        if (a >= amp_cmd_pkg::OFF_PAR1 && a <= amp_cmd_pkg::OFF_PAR5 && a[1:0] == 2'h0)
            rdMux = par[3'((a - amp_cmd_pkg::OFF_PAR1) >> 2)];
        else if (a == amp_cmd_pkg::OFF_ACK)
            rdMux = {21'h0, nAns, ack};
        else if (a >= amp_cmd_pkg::OFF_ANS1 && a <= amp_cmd_pkg::OFF_ANS5 && a[1:0] == 2'h0)
            rdMux = ans[3'((a - amp_cmd_pkg::OFF_ANS1) >> 2)];
        else if (a == amp_cmd_pkg::OFF_STATUS)
            rdMux = {29'h0, status};
        else if (a == amp_cmd_pkg::OFF_MASK)
            rdMux = {29'h0, mask};
        else if (a == amp_cmd_pkg::OFF_LIMIT)
            rdMux = {28'h0, limitClosed};
        else
            rdMux = 32'h0;
    endfunction

    always_comb
    begin
        next_waitrequest = !((read || write) && waitrequest);
        next_readdata = (read && waitrequest) ? rdMux(address) : readdata;
        wrAcc = write && !waitrequest;
        cmdGo = wrAcc && address == amp_cmd_pkg::OFF_CMD;
        opc = writedata[2:0];
    end

    // --------------------------------------------------------------
    // command execution
    // --------------------------------------------------------------
    always_comb
    begin
        next_par = par;
        next_ans = ans;
        next_ack = ack;
        next_nAns = nAns;
        next_assignCode = assignCode;
        next_storeCfg = storeCfg;
        next_limCfg = limCfg;
        next_mask = mask;
        next_clearPeak = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            if (wrAcc && address == 6'(amp_cmd_pkg::OFF_PAR1 + 6'(i * 4)))
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (byteenable[b])
                        next_par[i][b*8 +: 8] = writedata[b*8 +: 8];
                end
            end
        end
        if (wrAcc && address == amp_cmd_pkg::OFF_MASK)
            next_mask = writedata[2:0];
        if (cmdGo)
        begin
            next_nAns = 3'h0;
            case (opc)
                amp_cmd_pkg::OP_OUTPUT_ASSIGN:
                    if (ASSIGN_OK && (par[0] == 1 || par[0] == 2) && par[1] >= 0 && par[1] <= 4)
                    begin
                        next_assignCode[par[0] == 2] = par[1][2:0];
                        ok = 1'b1;
                    end
                amp_cmd_pkg::OP_OUTPUT_ASSIGN_QRY:
                    if (ASSIGN_OK && (par[0] == 1 || par[0] == 2))
                    begin
                        next_ans[0] = 32'(assignCode[par[0] == 2]);
                        next_nAns = 3'h1;
                        ok = 1'b1;
                    end
                amp_cmd_pkg::OP_PEAK_STORE_SETUP:
                    if ((par[0] == 1 || par[0] == 2) && (par[1] == 0 || par[1] == 1)
                        && par[2] >= -2 && par[2] <= 4 && par[2] != 0
                        && par[3] >= 0 && par[3] <= amp_cmd_pkg::ENV_MAX_MS)
                    begin
                        next_storeCfg[0].on = par[1][0];
                        next_storeCfg[1].on = par[1][0];
                        next_storeCfg[par[0] == 2].sig = par[2][3:0];
                        next_storeCfg[par[0] == 2].envMs = par[3][15:0];
                        ok = 1'b1;
                    end
                amp_cmd_pkg::OP_PEAK_STORE_QRY:
                    if (par[0] == 1 || par[0] == 2)
                    begin
                        next_ans[0] = par[0];
                        next_ans[1] = 32'(storeCfg[par[0] == 2].on);
                        next_ans[2] = 32'(storeCfg[par[0] == 2].sig);
                        next_ans[3] = 32'(storeCfg[par[0] == 2].envMs);
                        next_nAns = 3'h4;
                        ok = 1'b1;
                    end
                amp_cmd_pkg::OP_CLEAR_PEAK:
                begin
                    next_clearPeak = 1'b1;
                    ok = 1'b1;
                end
                amp_cmd_pkg::OP_LIMIT_SWITCH_SETUP:
                    if (par[0] >= 1 && par[0] <= 4 && (par[1] == 0 || par[1] == 1) && par[2] >= 1 && par[2] <= 5)
                    begin
                        next_limCfg[2'(par[0] - 1)] = {par[1][0], par[2][2:0], par[3], par[4]};
                        ok = 1'b1;
                    end
                amp_cmd_pkg::OP_LIMIT_SWITCH_QRY:
                    if (par[0] == 0 && par[1] >= 1 && par[1] <= 5)
                    begin
                        next_ans[0] = 32'(pick(par[1][2:0]));
                        next_nAns = 3'h1;
                        ok = 1'b1;
                    end
                    else if (par[0] >= 1 && par[0] <= 4)
                    begin
                        next_ans[0] = par[0];
                        next_ans[1] = 32'(limCfg[2'(par[0] - 1)].on);
                        next_ans[2] = 32'(limCfg[2'(par[0] - 1)].src);
                        next_ans[3] = limCfg[2'(par[0] - 1)].closePt;
                        next_ans[4] = limCfg[2'(par[0] - 1)].openPt;
                        next_nAns = 3'h5;
                        ok = 1'b1;
                    end
                default:
                    ok = 1'b0;
            endcase
            next_ack = ok ? amp_cmd_pkg::ACK_DONE : amp_cmd_pkg::ACK_ERROR;
        end
        err = cmdGo && !ok;
    end

    // --------------------------------------------------------------
    // limit switches, routing, interrupt
    // --------------------------------------------------------------
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            next_limitClosed[k] = limitClosed[k];
            if (!limCfg[k].on)
                next_limitClosed[k] = 1'b0;
            else if (pick(limCfg[k].src) >= limCfg[k].closePt)
                next_limitClosed[k] = 1'b1;
            else if (pick(limCfg[k].src) <= limCfg[k].openPt)
                next_limitClosed[k] = 1'b0;
        end
        for (int j = 0; j < 2; j++)
            next_aOut[j] = pick(assignCode[j]);
        next_status = (read && waitrequest && address == amp_cmd_pkg::OFF_STATUS) ? 3'h0 : status;
        next_status[amp_cmd_pkg::STAT_DONE] |= cmdGo && ok;
        next_status[amp_cmd_pkg::STAT_ERROR] |= err;
        next_status[amp_cmd_pkg::STAT_LIMIT] |= next_limitClosed != limitClosed;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            msCnt <= 32'h0;
            msTick <= 1'b0;
            readdata <= 32'h0;
            waitrequest <= 1'b1;
            par <= '{default: '0};
            ans <= '{default: '0};
            ack <= amp_cmd_pkg::ACK_DONE;
            nAns <= 3'h0;
            assignCode <= '{default: amp_cmd_pkg::SRC_UNLINKED};
            storeCfg <= '{default: '0};
            limCfg <= '{default: '0};
            mask <= 3'h0;
            clearPeak <= 1'b0;
            limitClosed <= 4'h0;
            status <= amp_cmd_pkg::STATUS_RESET;
            irq <= 1'b0;
            analog_out_first <= '0;
            analog_out_second <= '0;
        end
        else
        begin
            msCnt <= next_msCnt;
            msTick <= next_msTick;
            readdata <= next_readdata;
            waitrequest <= next_waitrequest;
            par <= next_par;
            ans <= next_ans;
            ack <= next_ack;
            nAns <= next_nAns;
            assignCode <= next_assignCode;
            storeCfg <= next_storeCfg;
            limCfg <= next_limCfg;
            mask <= next_mask;
            clearPeak <= next_clearPeak;
            limitClosed <= next_limitClosed;
            status <= next_status;
            irq <= next_irq;
            analog_out_first <= next_aOut[0];
            analog_out_second <= next_aOut[1];
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    property p_ack;
        cmdGo |=> (ack == (($past(ok)) ? amp_cmd_pkg::ACK_DONE : amp_cmd_pkg::ACK_ERROR))
            && ($past(ok) || status[amp_cmd_pkg::STAT_ERROR]);
    endproperty
    a_ack: assert property (p_ack) else $error("wrong acknowledgment");

    property p_rev;
        cmdGo && !ASSIGN_OK && (opc == amp_cmd_pkg::OP_OUTPUT_ASSIGN || opc == amp_cmd_pkg::OP_OUTPUT_ASSIGN_QRY)
        |=> ack == amp_cmd_pkg::ACK_ERROR;
    endproperty
    a_rev: assert property (p_rev) else $error("assign accepted on late revision");

    property p_assign;
        cmdGo && ASSIGN_OK && opc == amp_cmd_pkg::OP_OUTPUT_ASSIGN && par[0] == 1 && par[1] == 2
        |=> assignCode[0] == amp_cmd_pkg::SRC_NET ##1 analog_out_first == $past(net_signal);
    endproperty
    a_assign: assert property (p_assign) else $error("output not routed to net");

    property p_assign_qry;
        cmdGo && opc == amp_cmd_pkg::OP_OUTPUT_ASSIGN_QRY && ASSIGN_OK && par[0] == 2
        |=> ans[0] == 32'(assignCode[1]) && nAns == 3'h1;
    endproperty
    a_assign_qry: assert property (p_assign_qry) else $error("assign query wrong");

    property p_both_on;
        cmdGo && opc == amp_cmd_pkg::OP_PEAK_STORE_SETUP && ok |=> storeCfg[0].on == storeCfg[1].on;
    endproperty
    a_both_on: assert property (p_both_on) else $error("stores switched apart");

    property p_limit_close;
        limCfg[0].on && pick(limCfg[0].src) >= limCfg[0].closePt |=> limitClosed[0];
    endproperty
    a_limit_close: assert property (p_limit_close) else $error("switch did not close");

    property p_limit_hold;
        limCfg[0].on && pick(limCfg[0].src) < limCfg[0].closePt && pick(limCfg[0].src) > limCfg[0].openPt
        |=> limitClosed[0] == $past(limitClosed[0]);
    endproperty
    a_limit_hold: assert property (p_limit_hold) else $error("switch moved between points");

    property p_wait;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest sequence wrong");

    property p_irq;
        cmdGo && ok && mask[amp_cmd_pkg::STAT_DONE] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    c_clear: cover property (cmdGo && opc == amp_cmd_pkg::OP_CLEAR_PEAK);
    c_limit: cover property (!limitClosed[0] ##1 limitClosed[0]);
    c_full: cover property (gross_signal == amp_cmd_pkg::ADU_FULL_SCALE);
    c_err: cover property (err);
endmodule

/* verif/amp_host_model.sv */
`timescale 1ns/100ps
module amp_host_model (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    initial
        {address, read, write, writedata} = '0;
    // one held request; codes and signed adu points as given
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        do
            @(posedge clk);
        while (waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

/* verif/peak_store_limit_monitor_cmds_tb_top.sv */
`timescale 1ns/100ps
module peak_store_limit_monitor_cmds_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, read, write, waitrequest, irq;
    logic [5:0] address;
    logic [3:0] byteenable = 4'hF, limitClosed;
    logic [31:0] writedata, readdata, q;
    logic signed [31:0] measIn = 0, tareValue = 100, absolute_signal = 77, analog_out_first, analog_out_second;
    int num_errors = 0, comparisons = 0;
    amp_cmd_core #(.MS_CYCLES(4)) i_amp_cmd_core (.*);
    amp_host_model i_amp_host_model (.*);
    initial
        forever #25 clk = ~clk;
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    task automatic complete_run;
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
            $display("BAD %s expected %0h seen %0h", n, e, s);
        num_errors += int'(s !== e);
    endtask
    task automatic look(input logic [5:0] a, input logic [31:0] e);
        i_amp_host_model.xfer(1'b1, a, 32'h0, q);
        chk($sformatf("reg %0h", a), q, e);
    endtask
    task automatic cmd(input logic [2:0] op, input int p[5], input logic [7:0] ack);
        for (int i = 0; i < 5; i++)
            i_amp_host_model.xfer(1'b0, 6'(amp_cmd_pkg::OFF_PAR1 + 4 * i), p[i], q);
        i_amp_host_model.xfer(1'b0, amp_cmd_pkg::OFF_CMD, {29'h0, op}, q);
        i_amp_host_model.xfer(1'b1, amp_cmd_pkg::OFF_ACK, 32'h0, q);
        chk("ack", {24'h0, q[7:0]}, {24'h0, ack});
        repeat (3) @(negedge clk);
    endtask
    task automatic apply(input int v);
        @(posedge clk);
        measIn <= v;
        repeat (4) @(negedge clk);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        look(6'h18, 32'h30); // reset ack
        apply(1000);
        cmd(3'h1, '{1, 2, 0, 0, 0}, 8'h30); // route net
        chk("out1", analog_out_first, 900); // net out
        cmd(3'h2, '{1, 0, 0, 0, 0}, 8'h30); // route query
        look(6'h1C, 2); // routed code
        cmd(3'h1, '{2, 5, 0, 0, 0}, 8'h3F); // bad code
        cmd(3'h3, '{2, 0, -2, 7, 0}, 8'h30); // store two off
        cmd(3'h4, '{1, 0, 0, 0, 0}, 8'h30); // store query
        look(6'h20, 0); // store one off too
        cmd(3'h4, '{2, 0, 0, 0, 0}, 8'h30); // store two query
        look(6'h24, -2); // signed net minimum code
        look(6'h28, 7); // envelope ms
        cmd(3'h3, '{1, 1, 1, 0, 0}, 8'h30); // store one max
        cmd(3'h1, '{2, 3, 0, 0, 0}, 8'h30); // out2 from store
        apply(2000);
        apply(800);
        chk("max", analog_out_second, 2000); // peak kept
        cmd(3'h5, '{0, 0, 0, 0, 0}, 8'h30); // clear
        chk("clear", analog_out_second, 800); // follows input
        cmd(3'h6, '{1, 1, 1, 3840000, -3840000}, 8'h30); // switch one
        apply(3840000);
        chk("close", limitClosed, 1); // closes
        apply(0);
        look(6'h38, 1); // holds
        apply(-3840000);
        chk("open", limitClosed, 0); // opens
        cmd(3'h7, '{1, 0, 0, 0, 0}, 8'h30); // switch query
        look(6'h2C, -3840000); // open point
        i_amp_host_model.xfer(1'b0, 6'h34, 32'h1, q);
        cmd(3'h7, '{0, 5, 0, 0, 0}, 8'h30); // level query
        look(6'h1C, 77); // absolute level
        chk("irq set", irq, 1);
        look(6'h30, 7);
        repeat (3) @(negedge clk);
        chk("irq clear", irq, 0);
        complete_run();
    end
endmodule
